// File: verilog/csg_clock_sync.sv
//----------------------------------------------------------------------
// Purpose: System clock division, frame and cascade sync, ref compare
// Assumes: Clock and sync pins sampled at the register clock
// Notes:   Sync pins are active low and idle high when left open
//----------------------------------------------------------------------
// What this block does
// RULE1: Select high: system clock out is operating clock / 4.
// RULE2: Select low: system clock out is crystal clock / 2.
// RULE3: System clock out runs at 8.192 MHz, maskable.
// RULE4: Quarter clock out is system clock in / 2, maskable.
// RULE5: Maskable control output for the 32.768 MHz oscillator.
// RULE6: Far side supplies the 8.192 MHz system clock input.
// RULE7: Sync in plus offsets set frame and multiframe phase.
// RULE8: No control interface: sync in period 125 us multiple.
// RULE9: Control interface: sync in period 4 ms multiple.
// RULE10: Unused sync in is open or high, treated inactive.
// RULE11: Sync out every 125 us, one or two periods wide.
// RULE12: No sync in, no control interface: sync out is reference.
// RULE13: Own oscillator: cascade sync out 488 ns every 125 us.
// RULE14: Cascade sync out also aligns external control devices.
// RULE15: Borrowed oscillator: align to cascade sync in.
// RULE16: Reference select: 00 far, 01 near, 1x external.
// RULE17: Compare reference with crystal clock, drive its control.
// RULE18: Far frame sync pulse used only when select bit 5 is 0.
// RULE19: Near frame sync pulse used only when select bit 5 is 1.
// RULE20: Dividers and sync generators reset to fixed phase; masks hold low.
`timescale 1ns/100ps
module csg_clock_sync #(
   parameter int FRAME_SCLKS = csg_pkg::FRAME_SCLKS,
   parameter int MFRAME_FRAMES = csg_pkg::MFRAME_FRAMES
) (
   // Clock, reset, enable
   input wire logic i_mclk,
   input wire logic i_rstn,
   input wire logic i_ce,
   // Register port
   input wire logic [csg_pkg::ADDR_W-1:0] i_addr,
   input wire logic [csg_pkg::DATA_W-1:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [csg_pkg::DATA_W-1:0] o_rdata,
   // Clock pins
   input wire logic i_clk_source_select,
   input wire logic i_operating_clock_32m,
   input wire logic i_crystal_osc_clock,
   input wire logic i_system_clock_in,
   input wire logic i_far_reference_clock,
   input wire logic i_near_reference_clock,
   input wire logic i_external_reference_clock,
   // Sync pins, active low
   input wire logic i_frame_sync_in_n,
   input wire logic i_cascade_sync_in_n,
   input wire logic i_far_frame_sync_pulse_n,
   input wire logic i_near_frame_sync_pulse_n,
   // Clock outputs
   output logic o_system_clock_out,
   output logic o_quarter_clock_out,
   output csg_pkg::csg_tune_t o_osc32_control_out,
   output csg_pkg::csg_tune_t o_crystal_osc_control_out,
   // Sync outputs
   output logic o_frame_sync_out_n,
   output logic o_cascade_sync_out_n,
   output logic o_frame_mark,
   output logic o_multiframe_mark,
   output logic o_rx_frame_mark
);
   localparam int FW = $clog2(FRAME_SCLKS);
   localparam int MW = $clog2(MFRAME_FRAMES);
   localparam int NP = csg_pkg::NPINS;
   localparam logic [FW-1:0] FRAME_LAST = FW'(FRAME_SCLKS - 1);
   localparam logic [MW-1:0] MF_LAST = MW'(MFRAME_FRAMES - 1);
   localparam logic [FW-1:0] CSC_LEN = FW'(csg_pkg::CASCADE_SCLKS);
   localparam logic [4:0] XO_NOM = 5'(csg_pkg::XO_PER_REF);
   localparam logic [4:0] OP_NOM = 5'(csg_pkg::OP_PER_REF);

   // Edge count against nominal: fewer means oscillator too slow
   function automatic csg_pkg::csg_tune_t tune(input logic [4:0] n,
                                               input logic [4:0] nom);
      csg_pkg::csg_tune_t t;
      t.up = n < nom;
      t.dn = n > nom;
      return t;
   endfunction

   //------------------------------------------------
   // Pin synchronisers
   //------------------------------------------------
   logic [NP-1:0] pins;
   logic [NP-1:0] meta_r;
   logic [NP-1:0] sync_r;
   logic [NP-1:0] prev_r;
   logic [NP-1:0] rise;
   logic [NP-1:0] fall;

   assign pins = {i_clk_source_select, i_near_frame_sync_pulse_n,
                  i_far_frame_sync_pulse_n, i_cascade_sync_in_n,
                  i_frame_sync_in_n, i_external_reference_clock,
                  i_near_reference_clock, i_far_reference_clock,
                  i_system_clock_in, i_crystal_osc_clock,
                  i_operating_clock_32m};
   assign rise = sync_r & ~prev_r;
   assign fall = ~sync_r & prev_r;

   // RULE10: idle high is inactive
   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         meta_r <= {NP{1'b1}};
         sync_r <= {NP{1'b1}};
         prev_r <= {NP{1'b1}};
      end else if (i_ce) begin
         meta_r <= pins;
         sync_r <= meta_r;
         prev_r <= sync_r;
      end
   end

   //------------------------------------------------
   // Registers
   //------------------------------------------------
   csg_pkg::csg_ctrl_t ctrl_r;
   logic [1:0] refsel_r;
   logic [csg_pkg::ALIGN_W-1:0] align_r;
   logic [csg_pkg::DATA_W-1:0] rdata_nxt;
   logic [csg_pkg::DATA_W-1:0] status;
   logic [MW-1:0] mf_cnt_r;
   csg_pkg::csg_frame_src_t src;
   csg_pkg::csg_tune_t xo_tune_r;
   csg_pkg::csg_tune_t op_tune_r;

   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         ctrl_r <= csg_pkg::CTRL_RESET;
         refsel_r <= csg_pkg::REFSEL_RESET;
         align_r <= csg_pkg::ALIGN_RESET;
      end else if (i_ce && i_wr) begin
         if (i_addr == csg_pkg::ADDR_CTRL) begin
            ctrl_r <= i_wdata[5:0];
         end else if (i_addr == csg_pkg::ADDR_REFSEL) begin
            refsel_r <= i_wdata[csg_pkg::REFSEL_HI:csg_pkg::REFSEL_LO];
         end else if (i_addr == csg_pkg::ADDR_ALIGN) begin
            align_r <= i_wdata[csg_pkg::ALIGN_W-1:0];
         end
      end
   end

   assign status = {3'h0, 5'(mf_cnt_r), op_tune_r, xo_tune_r,
                    sync_r[csg_pkg::PIN_SRC_SEL], src};
   assign rdata_nxt =
      (i_addr == csg_pkg::ADDR_CTRL) ? {10'h000, ctrl_r} :
      (i_addr == csg_pkg::ADDR_REFSEL) ? {9'h000, refsel_r, 5'h00} :
      (i_addr == csg_pkg::ADDR_ALIGN) ? {6'h00, align_r} :
      (i_addr == csg_pkg::ADDR_STATUS) ? status : 16'h0000;

   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_rdata <= 16'h0000;
      end else if (i_ce) begin
         o_rdata <= i_rd ? rdata_nxt : 16'h0000;
      end
   end

   //------------------------------------------------
   // Clock dividers
   //------------------------------------------------
   logic op_clk;
   logic op_rise;
   logic xo_clk;
   logic xo_rise;
   logic q_clk;
   logic sclk;
   logic sclk_rise;

   // RULE1: operating clock over four
   csg_edge_div #(.DIV(csg_pkg::DIV_OP32)) u_div_op (
      .i_mclk(i_mclk), .i_rstn(i_rstn), .i_ce(i_ce),
      .i_edge(rise[csg_pkg::PIN_OP32]),
      .o_clk(op_clk), .o_rise(op_rise));

   // RULE2: crystal clock over two
   csg_edge_div #(.DIV(csg_pkg::DIV_XO16)) u_div_xo (
      .i_mclk(i_mclk), .i_rstn(i_rstn), .i_ce(i_ce),
      .i_edge(rise[csg_pkg::PIN_XO16]),
      .o_clk(xo_clk), .o_rise(xo_rise));

   // RULE4: system clock in over two
   csg_edge_div #(.DIV(csg_pkg::DIV_SYSIN)) u_div_q (
      .i_mclk(i_mclk), .i_rstn(i_rstn), .i_ce(i_ce),
      .i_edge(rise[csg_pkg::PIN_SYSIN]),
      .o_clk(q_clk), .o_rise());

   // RULE3: source select picks the 8.192 MHz source
   assign sclk = sync_r[csg_pkg::PIN_SRC_SEL] ? op_clk : xo_clk;
   assign sclk_rise = sync_r[csg_pkg::PIN_SRC_SEL] ? op_rise : xo_rise;

   // RULE20: masked clocks hold low
   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_system_clock_out <= 1'b0;
         o_quarter_clock_out <= 1'b0;
      end else if (i_ce) begin
         o_system_clock_out <= sclk && !ctrl_r.sclk_mask;
         o_quarter_clock_out <= q_clk && !ctrl_r.clk4_mask;
      end
   end

   //------------------------------------------------
   // Frame timing
   //------------------------------------------------
   logic [FW-1:0] frm_cnt_r;
   logic ext_sync;
   logic csc_sync;
   logic resync;
   logic frame_wrap;
   logic ext_seen_r;

   // RULE15: borrowed oscillator follows cascade sync in
   assign csc_sync = !ctrl_r.own_osc && fall[csg_pkg::PIN_CSYNC];
   // RULE7: sync input fixes frame phase
   assign ext_sync = fall[csg_pkg::PIN_FSYNC];
   assign resync = ext_sync || csc_sync;
   assign frame_wrap = sclk_rise && (frm_cnt_r == FRAME_LAST);
   // RULE12: free-running frame is the reference with own oscillator, no sync in seen and no control interface
   assign src = csc_sync || (!ctrl_r.own_osc && !ext_seen_r) ?
                csg_pkg::FR_CASCADE :
                (ext_seen_r || ctrl_r.control_comm_interface_used) ? csg_pkg::FR_EXT :
                csg_pkg::FR_FREE;

   // RULE20: frame counters start at zero
   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         frm_cnt_r <= '0;
         mf_cnt_r <= '0;
         ext_seen_r <= 1'b0;
      end else if (i_ce) begin
         ext_seen_r <= ext_seen_r || ext_sync;
         if (resync) begin
            frm_cnt_r <= '0;
            // RULE9: multiframe realigns on sync in; on cascade sync in only with control interface
            if (ctrl_r.control_comm_interface_used || ext_sync) begin
               mf_cnt_r <= '0;
            end
         end else if (sclk_rise) begin
            frm_cnt_r <= frm_cnt_r + 1'b1;
            if (frame_wrap) begin
               mf_cnt_r <= (mf_cnt_r == MF_LAST) ? '0 : mf_cnt_r + 1'b1;
            end
         end
      end
   end

   //------------------------------------------------
   // Sync outputs and alignment marks
   //------------------------------------------------
   logic [FW-1:0] align_pos;
   logic sync_on;
   logic csc_on;
   logic at_align;

   assign align_pos = FW'(align_r);
   // RULE11: one or two periods from frame start
   assign sync_on = (frm_cnt_r == '0) ||
                    (ctrl_r.sync_wide && frm_cnt_r == FW'(1));
   // RULE13: 488 ns as whole system clock periods
   assign csc_on = ctrl_r.own_osc && (frm_cnt_r < CSC_LEN);
   assign at_align = sclk_rise && (frm_cnt_r == align_pos);

   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_frame_sync_out_n <= 1'b1;
         o_cascade_sync_out_n <= 1'b1;
         o_frame_mark <= 1'b0;
         o_multiframe_mark <= 1'b0;
      end else if (i_ce) begin
         o_frame_sync_out_n <= !sync_on;
         // RULE14: cascade sync out tracks frame phase
         o_cascade_sync_out_n <= !csc_on;
         // RULE7: offset shifts the frame mark
         o_frame_mark <= at_align;
         o_multiframe_mark <= at_align && (mf_cnt_r == '0) &&
                              ctrl_r.control_comm_interface_used;
      end
   end

   //------------------------------------------------
   // Reference selection and frequency compare
   //------------------------------------------------
   logic ref_rise;
   logic [4:0] xo_cnt_r;
   logic [4:0] op_cnt_r;
   logic rx_fsp;

   // RULE16: 00 far, 01 near, 1x external
   assign ref_rise = refsel_r[1] ? rise[csg_pkg::PIN_REF_EXT] :
                     refsel_r[0] ? rise[csg_pkg::PIN_REF_NEAR] :
                     rise[csg_pkg::PIN_REF_FAR];
   // RULE18: far pulse on bit 5 clear
   // RULE19: near pulse on bit 5 set
   assign rx_fsp = refsel_r[0] ? fall[csg_pkg::PIN_NEAR_FSP] :
                   fall[csg_pkg::PIN_FAR_FSP];

   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         xo_cnt_r <= 5'h00;
         op_cnt_r <= 5'h00;
         xo_tune_r <= 2'h0;
         op_tune_r <= 2'h0;
         o_rx_frame_mark <= 1'b0;
      end else if (i_ce) begin
         o_rx_frame_mark <= rx_fsp;
         if (ref_rise) begin
            // RULE17: crystal edges per reference period
            xo_tune_r <= tune(xo_cnt_r, XO_NOM);
            op_tune_r <= tune(op_cnt_r, OP_NOM);
            xo_cnt_r <= 5'(rise[csg_pkg::PIN_XO16]);
            op_cnt_r <= 5'(rise[csg_pkg::PIN_OP32]);
         end else begin
            if (rise[csg_pkg::PIN_XO16] && xo_cnt_r != 5'h1F) begin
               xo_cnt_r <= xo_cnt_r + 5'h01;
            end
            if (rise[csg_pkg::PIN_OP32] && op_cnt_r != 5'h1F) begin
               op_cnt_r <= op_cnt_r + 5'h01;
            end
         end
      end
   end

   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_crystal_osc_control_out <= 2'h0;
         o_osc32_control_out <= 2'h0;
      end else if (i_ce) begin
         o_crystal_osc_control_out <= xo_tune_r;
         // RULE5: masked control holds neutral
         o_osc32_control_out <= ctrl_r.osc32_mask ? 2'h0 : op_tune_r;
      end
   end
endmodule

// File: verilog/csg_pkg.sv
//----------------------------------------------------------------------
// Purpose: Constants and types of the clock and frame sync unit
// Assumes: 10 MHz register clock, pins sampled through synchronisers
// Notes:   Register offsets are word indices
//----------------------------------------------------------------------
package csg_pkg;

   //------------------------------------------------
   // Register map
   //------------------------------------------------
   localparam int ADDR_W = 4;
   localparam int DATA_W = 16;
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_REFSEL = 4'h1;
   localparam logic [3:0] ADDR_ALIGN = 4'h2;
   localparam logic [3:0] ADDR_STATUS = 4'h3;

   // Control register fields
   localparam int CTRL_SCLK_MASK = 0;
   localparam int CTRL_CLK4_MASK = 1;
   localparam int CTRL_OSC32_MASK = 2;
   localparam int CTRL_SYNC_WIDE = 3;
   localparam int CTRL_CONTROL_COMM_INTERFACE_USED = 4;
   localparam int CTRL_OWN_OSC = 5;
   localparam logic [5:0] CTRL_RESET = 6'h00;

   // Reference select field lies in bits 6:5
   localparam int REFSEL_LO = 5;
   localparam int REFSEL_HI = 6;
   localparam logic [1:0] REFSEL_RESET = 2'h0;
   localparam int ALIGN_W = 10;
   localparam logic [9:0] ALIGN_RESET = 10'h000;

   //------------------------------------------------
   // Clock ratios and timing
   //------------------------------------------------
   localparam int DIV_OP32 = 4;
   localparam int DIV_XO16 = 2;
   localparam int DIV_SYSIN = 2;
   localparam int FRAME_NS = 125000;
   localparam int SCLK_PERIOD_NS = 122;
   localparam int FRAME_SCLKS = 1024;
   localparam int CASCADE_NS = 488;
   localparam int CASCADE_SCLKS = (CASCADE_NS + SCLK_PERIOD_NS - 1) /
                                  SCLK_PERIOD_NS;
   localparam int MFRAME_FRAMES = 32;
   localparam int XO_PER_REF = 8;
   localparam int OP_PER_REF = 16;

   //------------------------------------------------
   // Pin input indices
   //------------------------------------------------
   localparam int PIN_OP32 = 0;
   localparam int PIN_XO16 = 1;
   localparam int PIN_SYSIN = 2;
   localparam int PIN_REF_FAR = 3;
   localparam int PIN_REF_NEAR = 4;
   localparam int PIN_REF_EXT = 5;
   localparam int PIN_FSYNC = 6;
   localparam int PIN_CSYNC = 7;
   localparam int PIN_FAR_FSP = 8;
   localparam int PIN_NEAR_FSP = 9;
   localparam int PIN_SRC_SEL = 10;
   localparam int NPINS = 11;

   typedef struct packed {
      logic own_osc;
      logic control_comm_interface_used;
      logic sync_wide;
      logic osc32_mask;
      logic clk4_mask;
      logic sclk_mask;
   } csg_ctrl_t;

   typedef struct packed {
      logic up;
      logic dn;
   } csg_tune_t;

   typedef enum logic [2:0] {
      FR_FREE = 3'b001,
      FR_EXT = 3'b010,
      FR_CASCADE = 3'b100
   } csg_frame_src_t;

endpackage

// File: verilog/csg_edge_div.sv
//----------------------------------------------------------------------
// Purpose: Divides a stream of input edge pulses into a square wave
// Assumes: i_edge is a one-cycle pulse on the register clock
// Notes:   Output starts low after reset; o_rise marks each rising edge
//----------------------------------------------------------------------
`timescale 1ns/100ps
module csg_edge_div #(
   parameter int DIV = 4
) (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_rstn,
   input wire logic i_ce,
   // Edge stream
   input wire logic i_edge,
   // Divided clock
   output logic o_clk,
   output logic o_rise
);
   localparam int CW = $clog2(DIV) + 1;
   localparam logic [CW-1:0] HALF = CW'(DIV / 2 - 1);

   logic [CW-1:0] cnt_r;
   logic wrap;

   assign wrap = i_edge && (cnt_r == HALF);

   // RULE20: defined phase
   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         cnt_r <= '0;
         o_clk <= 1'b0;
         o_rise <= 1'b0;
      end else if (i_ce) begin
         cnt_r <= wrap ? '0 : (i_edge ? cnt_r + 1'b1 : cnt_r);
         o_clk <= wrap ? ~o_clk : o_clk;
         o_rise <= wrap && !o_clk;
      end
   end
endmodule

// File: sim/csg_far_model.sv
// Purpose: Framer, sibling and oscillator pins seen by the sync unit
// Assumes: Pin clocks slowed to register clock scale
// Notes:   Sync pins idle high, request pulses go low for four cycles
`timescale 1ns/100ps
module csg_far_model (
   // Clock
   input wire logic i_mclk,
   // Pulse requests: frame, cascade, far, near
   input wire logic [3:0] i_pulse_req,
   // Clock pins: ext ref, near ref, far ref, sysin, crystal, op
   output logic [5:0] o_clk,
   // Sync pins, active low
   output logic [3:0] o_sync_n
);
   int cyc = 0;
   logic [1:0] hold [4] = '{default: 2'h0};
   initial begin
      o_clk = 6'h00;
      o_sync_n = 4'hF;
   end
   always @(posedge i_mclk) begin
      cyc <= cyc + 1;
      o_clk[0] <= (cyc % 6) < 3;
      o_clk[1] <= (cyc % 8) < 4;
      o_clk[2] <= (cyc % 4) < 2;
      o_clk[3] <= (cyc % 56) < 28;
      o_clk[4] <= (cyc % 72) < 36;
      o_clk[5] <= (cyc % 64) < 32;
      for (int k = 0; k < 4; k++) begin
         if (i_pulse_req[k]) begin
            hold[k] <= 2'h3;
         end else if (hold[k] != 2'h0) begin
            hold[k] <= hold[k] - 2'h1;
         end
         o_sync_n[k] <= !(i_pulse_req[k] || hold[k] != 2'h0);
      end
   end
endmodule

// File: sim/csg_clock_sync_properties.sv
// Purpose: Port checker of the clock and frame sync unit
// Assumes: Control bits are shadowed from the register port
// Notes:   Pulse widths count system clock out rises
`timescale 1ns/100ps
module csg_clock_sync_chk #(
   parameter int FRAME_SCLKS = csg_pkg::FRAME_SCLKS,
   parameter int MFRAME_FRAMES = csg_pkg::MFRAME_FRAMES
) (
   input wire logic i_mclk,
   input wire logic i_rstn,
   input wire logic i_ce,
   input wire logic [csg_pkg::ADDR_W-1:0] i_addr,
   input wire logic [csg_pkg::DATA_W-1:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_far_frame_sync_pulse_n,
   input wire logic i_near_frame_sync_pulse_n,
   input wire logic o_system_clock_out,
   input wire logic o_quarter_clock_out,
   input wire csg_pkg::csg_tune_t o_osc32_control_out,
   input wire csg_pkg::csg_tune_t o_crystal_osc_control_out,
   input wire logic o_frame_sync_out_n,
   input wire logic o_cascade_sync_out_n,
   input wire logic o_frame_mark,
   input wire logic o_multiframe_mark,
   input wire logic o_rx_frame_mark
);
   csg_pkg::csg_ctrl_t ctl_r;
   logic sel5_r, sys_q_r, far_q_r, near_q_r;
   logic [3:0] sw_r, cw_r, since_r;
   wire logic sys_rise = o_system_clock_out & ~sys_q_r;
   wire logic far_fall = far_q_r & ~i_far_frame_sync_pulse_n;
   wire logic near_fall = near_q_r & ~i_near_frame_sync_pulse_n;
   wire logic sel_fall = sel5_r ? near_fall : far_fall;
   wire logic [3:0] sw_max = ctl_r.sync_wide ? 4'h3 : 4'h2;
   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         ctl_r <= csg_pkg::CTRL_RESET;
         sel5_r <= 1'b0;
         {sys_q_r, far_q_r, near_q_r} <= 3'h7;
         {sw_r, cw_r, since_r} <= 12'h00F;
      end else begin
         if (i_ce && i_wr && i_addr == csg_pkg::ADDR_CTRL) begin
            ctl_r <= i_wdata[5:0];
         end
         if (i_ce && i_wr && i_addr == csg_pkg::ADDR_REFSEL) begin
            sel5_r <= i_wdata[csg_pkg::REFSEL_LO];
         end
         sys_q_r <= o_system_clock_out;
         far_q_r <= i_far_frame_sync_pulse_n;
         near_q_r <= i_near_frame_sync_pulse_n;
         sw_r <= o_frame_sync_out_n ? 4'h0 : sw_r + {3'h0, sys_rise};
         cw_r <= o_cascade_sync_out_n ? 4'h0 : cw_r + {3'h0, sys_rise};
         since_r <= sel_fall ? 4'h0 : since_r + {3'h0, since_r != 4'hF};
      end
   end
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_rstn);
   a_sclk_masked: assert property (
      ctl_r.sclk_mask && $past(ctl_r.sclk_mask, 2) |-> !o_system_clock_out)
      else $error("sclk out while masked");
   a_clk4_masked: assert property (
      ctl_r.clk4_mask && $past(ctl_r.clk4_mask, 2) |-> !o_quarter_clock_out)
      else $error("clk4 out while masked");
   a_osc32_masked: assert property (
      ctl_r.osc32_mask && $past(ctl_r.osc32_mask, 2)
      |-> o_osc32_control_out == 2'h0)
      else $error("osc32 ctrl while masked");
   a_cascade_own: assert property (
      !ctl_r.own_osc && !$past(ctl_r.own_osc, 2) |-> o_cascade_sync_out_n)
      else $error("cascade out without own osc");
   a_cascade_width: assert property (cw_r <= 4'h5)
      else $error("cascade out too wide");
   a_sync_width: assert property (sw_r <= sw_max)
      else $error("sync out too wide");
   a_rx_cause: assert property (o_rx_frame_mark |-> since_r <= 4'h6)
      else $error("rx mark without pulse");
   a_mark_single: assert property (o_frame_mark |=> !o_frame_mark)
      else $error("frame mark too long");
   a_mframe_in_frame: assert property (
      o_multiframe_mark |-> o_frame_mark)
      else $error("lone multiframe mark");
   a_tune_exclusive: assert property (
      o_crystal_osc_control_out != 2'h3)
      else $error("crystal up and down");
   c_cascade: cover property ($fell(o_cascade_sync_out_n));
   c_rx_mark: cover property (o_rx_frame_mark);
   c_tune_up: cover property (o_crystal_osc_control_out.up);
endmodule
bind csg_clock_sync csg_clock_sync_chk #(
   .FRAME_SCLKS(FRAME_SCLKS),
   .MFRAME_FRAMES(MFRAME_FRAMES)
) i_chk (
   .i_mclk(i_mclk), .i_rstn(i_rstn), .i_ce(i_ce), .i_addr(i_addr),
   .i_wdata(i_wdata), .i_wr(i_wr),
   .i_far_frame_sync_pulse_n(i_far_frame_sync_pulse_n),
   .i_near_frame_sync_pulse_n(i_near_frame_sync_pulse_n),
   .o_system_clock_out(o_system_clock_out),
   .o_quarter_clock_out(o_quarter_clock_out),
   .o_osc32_control_out(o_osc32_control_out),
   .o_crystal_osc_control_out(o_crystal_osc_control_out),
   .o_frame_sync_out_n(o_frame_sync_out_n),
   .o_cascade_sync_out_n(o_cascade_sync_out_n),
   .o_frame_mark(o_frame_mark), .o_multiframe_mark(o_multiframe_mark),
   .o_rx_frame_mark(o_rx_frame_mark)
);

// File: sim/clock_sync_generation_tb_top.sv
// Purpose: Self-checking bench of the clock and frame sync unit
// Assumes: Frame of 16 system clock out periods
// Notes:   Pin clocks come from the far model
`timescale 1ns/100ps
module clock_sync_generation_tb_top;
   logic mclk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, src = 1'b1;
   logic [3:0] addr = 4'h0, preq = 4'h0;
   logic [15:0] wdata = 16'h0000, rdata, v;
   logic sclk, qclk, fso_n, cso_n, fmark, mmark, rxm;
   csg_pkg::csg_tune_t t32, t16;
   wire logic [5:0] pclk;
   wire logic [3:0] psync_n;
   wire logic [3:0] obs = {cso_n, fso_n, qclk, sclk};
   int mismatches = 0, checked = 0, w, p, n;
   always #50 mclk = ~mclk;
   csg_far_model i_csg_far_model (.i_mclk(mclk), .i_pulse_req(preq),
      .o_clk(pclk), .o_sync_n(psync_n));
   csg_clock_sync #(.FRAME_SCLKS(16), .MFRAME_FRAMES(4)) i_csg_clock_sync (
      .i_mclk(mclk), .i_rstn(rstn), .i_ce(1'b1), .i_addr(addr),
      .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
      .i_clk_source_select(src), .i_operating_clock_32m(pclk[0]),
      .i_crystal_osc_clock(pclk[1]), .i_system_clock_in(pclk[2]),
      .i_far_reference_clock(pclk[3]), .i_near_reference_clock(pclk[4]),
      .i_external_reference_clock(pclk[5]),
      .i_frame_sync_in_n(psync_n[0]), .i_cascade_sync_in_n(psync_n[1]),
      .i_far_frame_sync_pulse_n(psync_n[2]),
      .i_near_frame_sync_pulse_n(psync_n[3]),
      .o_system_clock_out(sclk), .o_quarter_clock_out(qclk),
      .o_osc32_control_out(t32), .o_crystal_osc_control_out(t16),
      .o_frame_sync_out_n(fso_n), .o_cascade_sync_out_n(cso_n),
      .o_frame_mark(fmark), .o_multiframe_mark(mmark),
      .o_rx_frame_mark(rxm));
   task chk(input logic [15:0] seen, input logic [15:0] exp,
                      input string what);
      checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task tick(input int c);
      repeat (c) @(posedge mclk);
      #1;
   endtask
   task wr_reg(input logic [3:0] a, input logic [15:0] d);
      @(posedge mclk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
   endtask
   task rd_reg(input logic [3:0] a, output logic [15:0] d);
      @(posedge mclk);
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask
   task measure(input int k, input logic lvl);
      n = 0;
      w = 0;
      while (obs[k] !== !lvl && n < 999) begin tick(1); n++; end
      while (obs[k] !== lvl && n < 999) begin tick(1); n++; end
      while (obs[k] === lvl && n < 999) begin tick(1); n++; w++; end
      p = w;
      while (obs[k] !== lvl && n < 999) begin tick(1); n++; p++; end
   endtask
   task t_reset;
      for (int a = 0; a < 3; a++) begin
         rd_reg(a[3:0], v);
         chk(v, 16'h0000, "reset register");
      end
      rd_reg(4'hF, v);
      chk(v, 16'h0000, "unmapped read");
      rd_reg(csg_pkg::ADDR_STATUS, v);
      chk(16'(v[2:0]), 16'h0004, "reset source");
   endtask
   task t_source;
      measure(0, 1'b1);
      chk(p[15:0], 16'd24, "sclk period op");
      src <= 1'b0;
      tick(20);
      measure(0, 1'b1);
      chk(p[15:0], 16'd16, "sclk period crystal");
      measure(1, 1'b1);
      chk(p[15:0], 16'd8, "quarter period");
   endtask
   task t_masks;
      wr_reg(csg_pkg::ADDR_CTRL, 16'h0007);
      tick(4);
      n = 0;
      repeat (40) begin
         tick(1);
         n += sclk + qclk + (t32 != 2'h0);
      end
      chk(n[15:0], 16'h0000, "masked outputs");
      wr_reg(csg_pkg::ADDR_CTRL, 16'h0000);
   endtask
   task t_sync;
      measure(2, 1'b0);
      chk({w[6:0], p[8:0]}, {7'd16, 9'd256}, "sync narrow");
      wr_reg(csg_pkg::ADDR_CTRL, 16'h0008);
      tick(70);
      measure(2, 1'b0);
      chk({w[6:0], p[8:0]}, {7'd32, 9'd256}, "sync wide");
      n = 0;
      repeat (80) begin
         tick(1);
         n += !cso_n;
      end
      chk(n[15:0], 16'h0000, "cascade quiet");
      wr_reg(csg_pkg::ADDR_CTRL, 16'h0020);
      tick(70);
      rd_reg(csg_pkg::ADDR_STATUS, v);
      chk(16'(v[2:0]), 16'h0001, "free source");
      measure(3, 1'b0);
      chk({w[6:0], p[8:0]}, {7'd64, 9'd256}, "cascade");
   endtask
   task automatic t_refsel;
      logic [1:0] exp [4] = '{2'b10, 2'b01, 2'b00, 2'b00};
      for (int s = 0; s < 4; s++) begin
         wr_reg(csg_pkg::ADDR_REFSEL, 16'(s << 5));
         tick(300);
         rd_reg(csg_pkg::ADDR_STATUS, v);
         chk(16'(v[5:4]), 16'(exp[s]), "status tune");
         chk(16'(t16), 16'(exp[s]), "crystal control");
      end
   endtask
   task t_rx;
      for (int s = 0; s < 2; s++) begin
         wr_reg(csg_pkg::ADDR_REFSEL, 16'(s << 5));
         for (int k = 2; k < 4; k++) begin
            tick(10);
            preq[k] <= 1'b1;
            tick(1);
            preq[k] <= 1'b0;
            n = 0;
            repeat (12) begin
               tick(1);
               n += rxm;
            end
            chk(n[15:0], 16'(k - 2 == s), "rx mark");
         end
      end
   endtask
   task t_resync;
      measure(2, 1'b0);
      tick(20);
      preq[0] <= 1'b1;
      tick(1);
      preq[0] <= 1'b0;
      n = 0;
      while (fso_n !== 1'b0 && n < 30) begin tick(1); n++; end
      chk(16'(n <= 8), 16'h0001, "resync delay");
      rd_reg(csg_pkg::ADDR_STATUS, v);
      chk(16'(v[2:0]), 16'h0002, "ext source");
   endtask
   task automatic print_verdict;
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge mclk);
      mismatches++;
      print_verdict();
   end
   initial begin
      repeat (16) @(posedge mclk);
      rstn <= 1'b1;
      t_reset();
      t_source();
      t_masks();
      t_sync();
      t_refsel();
      t_rx();
      t_resync();
      print_verdict();
   end
endmodule
